// >>> verilog/rid_pkg.sv
package rid_pkg;
    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 8;
    localparam int LADDR_W = 12;
    localparam int JADDR_W = 20;
    localparam int PTR_W = 21;
    localparam int BANK_W = 4;
    localparam int DEST_POS = 9;
    localparam int ACC_POS = 8;
    localparam int BIT_LSB = 9;
    localparam int FAST_POS = 8;
    localparam logic [3:0] SECOND_PREFIX = 4'hf;
    localparam logic [3:0] ACCESS_BANK = 4'h0;

    // ----------------------------------------
    // fixed control words
    // ----------------------------------------
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [15:0] OP_SLEEP = 16'h0003;
    localparam logic [15:0] OP_WDT_CLEAR = 16'h0004;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_DECIMAL_ADJUST = 16'h0007;
    localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;

    // ----------------------------------------
    // flag effect masks {c, dc, z, ov, n}
    // ----------------------------------------
    localparam logic [4:0] FX_NONE = 5'h00;
    localparam logic [4:0] FX_ARITH = 5'h1f;
    localparam logic [4:0] FX_LOGIC = 5'h05;
    localparam logic [4:0] FX_ROT = 5'h15;
    localparam logic [4:0] FX_Z = 5'h04;
    localparam logic [4:0] FX_C = 5'h10;

    // ----------------------------------------
    // table pointer modes
    // ----------------------------------------
    localparam logic [1:0] TBL_NONE = 2'h0;
    localparam logic [1:0] TBL_POST_INC = 2'h1;
    localparam logic [1:0] TBL_POST_DEC = 2'h2;
    localparam logic [1:0] TBL_PRE_INC = 2'h3;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int PHASES_PER_CYCLE = 4;

    typedef enum logic [3:0] {
        RID_PH_DECODE = 4'b0001,
        RID_PH_READ = 4'b0010,
        RID_PH_PROCESS = 4'b0100,
        RID_PH_WRITE = 4'b1000
    } rid_phase_t;

    typedef enum logic [3:0] {
        RID_ST_FIRST = 4'b0001,
        RID_ST_MOVE2 = 4'b0010,
        RID_ST_JUMP2 = 4'b0100,
        RID_ST_FLUSH = 4'b1000
    } rid_state_t;
endpackage

// >>> verilog/rid_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// four phase instruction cycle sequencer
// ----------------------------------------
module rid_phase_gen (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // phase outputs
    output rid_pkg::rid_phase_t o_phase,
    output logic o_cycle_end
);
    rid_pkg::rid_phase_t phase_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            phase_reg <= rid_pkg::RID_PH_DECODE;
        end else begin
            unique case (phase_reg)
                rid_pkg::RID_PH_DECODE: phase_reg <= rid_pkg::RID_PH_READ;
                rid_pkg::RID_PH_READ: phase_reg <= rid_pkg::RID_PH_PROCESS;
                rid_pkg::RID_PH_PROCESS: phase_reg <= rid_pkg::RID_PH_WRITE;
                rid_pkg::RID_PH_WRITE: phase_reg <= rid_pkg::RID_PH_DECODE;
                default: phase_reg <= rid_pkg::RID_PH_DECODE;
            endcase
        end
    end

    assign o_phase = phase_reg;
    assign o_cycle_end = (phase_reg == rid_pkg::RID_PH_WRITE);
endmodule
`default_nettype wire

// >>> verilog/rid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - file operands always read before write
// - access bit zero forces access bank
// - destination bit picks accumulator or file
// - short file address is eight bits
// - bit ops carry three-bit bit number
// - byte ops: d bit9, a bit8
// - register move uses two twelve-bit words
// - table mode selects no pointer update or one of three
// - fast bit moves shadow registers
// - lone second word runs as nop
// - taken change of flow costs two cycles
// - skips cost one or two
// - port read-modify-write reads pins
// - timer-zero write clears assigned prescaler
// - table write two cycles, write continues
// - absolute call/jump carry twenty-bit address
// - relative branch/call eleven-bit offset
// - conditional branch codes, eight-bit offset
// - literal ops take low byte immediate
// - fixed control opcodes decoded exactly
// - returns take two cycles, interrupt returns reenable interrupts
// - flag effects per operation class
// - instruction cycle has four phases
module rid_decoder #(
    parameter int TIMER_ZERO_ADDR = 12'hfd6,
    parameter int PORT_B_ADDR = 12'hf81
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // fetch side
    input wire logic [15:0] i_instr,
    input wire logic i_instr_valid,
    // core status
    input wire logic [3:0] i_bank_select,
    input wire logic [4:0] i_status_flags,
    input wire logic i_skip_taken,
    input wire logic i_prescaler_on_timer,
    // decoded fields
    output logic [1:0] o_phase_code,
    output logic [11:0] o_file_addr,
    output logic o_file_read,
    output logic o_file_write,
    output logic o_dest_accum,
    output logic o_read_pins,
    output logic [2:0] o_bit_num,
    output logic [7:0] o_literal,
    output logic [11:0] o_move_src,
    output logic [11:0] o_move_dst,
    output logic o_move_valid,
    output logic [19:0] o_jump_addr,
    output logic o_jump_valid,
    output logic o_jump_call,
    output logic [10:0] o_rel_offset,
    output logic o_rel_valid,
    output logic o_rel_call,
    output logic [7:0] o_cond_offset,
    output logic o_cond_taken,
    output logic [1:0] o_tbl_mode,
    output logic o_tbl_read,
    output logic o_tbl_write,
    output logic o_fast,
    output logic o_return,
    output logic o_int_return,
    output logic o_reenable_int,
    output logic [4:0] o_flag_mask,
    output logic o_sleep,
    output logic o_wdt_clear,
    output logic o_push,
    output logic o_pop,
    output logic o_decimal_adjust,
    output logic o_soft_reset,
    output logic o_clear_prescaler,
    output logic o_exec_nop,
    output logic [1:0] o_cycles
);
    if (TIMER_ZERO_ADDR < 0 || TIMER_ZERO_ADDR > 12'hfff || PORT_B_ADDR < 0 || PORT_B_ADDR > 12'hfff) begin : g_addr_chk
        $error("address parameter out of range");
    end

    localparam logic [11:0] T0_ADDR = TIMER_ZERO_ADDR[11:0];
    localparam logic [11:0] PB_ADDR = PORT_B_ADDR[11:0];

    // ----------------------------------------
    // phase sequencer
    // ----------------------------------------
    rid_pkg::rid_phase_t phase;
    logic cycle_end;

    rid_phase_gen u_phase (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .o_phase(phase),
        .o_cycle_end(cycle_end)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [11:0] full_addr(input logic a, input logic [7:0] f, input logic [3:0] bank_select);
        full_addr = {(a ? bank_select : rid_pkg::ACCESS_BANK), f};
    endfunction

    function automatic logic cond_true(input logic [2:0] cc, input logic [4:0] fl);
        logic v;
        v = 1'b0;
        unique case (cc[2:1])
            2'h0: v = fl[2];
            2'h1: v = fl[4];
            2'h2: v = fl[1];
            2'h3: v = fl[0];
        endcase
        cond_true = v ^ cc[0];
    endfunction

    // ----------------------------------------
    // combinational classification
    // ----------------------------------------
    wire logic [15:0] w = i_instr;
    wire logic [3:0] top = w[15:12];
    logic is_byte, is_bit, is_lit, writes_file, is_skip, is_two_word_first;
    localparam int DEST_POS_L = rid_pkg::DEST_POS;

    always_comb begin
        is_byte = (top <= 4'h6) && !(top == 4'h0 && (w[11] || w[11:9] == 3'h0));
        is_bit = (top >= 4'h7) && (top <= 4'hb);
        is_lit = (top == 4'h0) && (w[11:8] >= 4'h8 || w[11:8] == 4'h1);
        writes_file = is_bit ? !(top[3] && top[1])
            : (is_byte && ((top == 4'h6) ? w[11] : (w[DEST_POS_L] && !(top == 4'h0 && w[11:10] == 2'h0))));
        is_skip = (is_bit && top[3] && top[1]) || (top == 4'h6 && w[11:9] <= 3'h3)
            || (top == 4'h2 && w[11:10] == 2'h3) || (top == 4'h3 && w[11:10] == 2'h3)
            || (top == 4'h4 && w[11] == 1'b1);
        is_two_word_first = (top == 4'hc) || (top == 4'he && w[11:9] == 3'h6) || (w[15:8] == 8'hef);
    end

    // ----------------------------------------
    // sequencing state
    // ----------------------------------------
    rid_pkg::rid_state_t state_reg;
    logic [15:0] first_reg;
    logic [1:0] cycles_next;
    logic flush_next;

    always_comb begin
        cycles_next = 2'h1;
        flush_next = 1'b0;
        if (is_two_word_first) begin
            cycles_next = 2'h2;
        end else if (top == 4'hd || (w[15:1] == 15'h0009) || (w[15:1] == 15'h0008)
            || (w[15:8] == 8'h0c)) begin
            cycles_next = 2'h2;
            flush_next = 1'b1;
        end else if (top == 4'he && !w[11] && cond_true(w[10:8], i_status_flags)) begin
            cycles_next = 2'h2;
            flush_next = 1'b1;
        end else if (w[15:3] == 13'h0001) begin
            cycles_next = 2'h2;
        end else if (is_skip && i_skip_taken) begin
            cycles_next = (i_instr[15:12] == rid_pkg::SECOND_PREFIX) ? 2'h3 : 2'h2;
            flush_next = 1'b1;
        end
    end

    wire logic take = i_instr_valid && cycle_end;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= rid_pkg::RID_ST_FIRST;
            first_reg <= 16'h0000;
        end else if (take) begin
            unique case (state_reg)
                rid_pkg::RID_ST_FIRST: begin
                    first_reg <= w;
                    if (top == 4'hc) begin
                        state_reg <= rid_pkg::RID_ST_MOVE2;
                    end else if (is_two_word_first) begin
                        state_reg <= rid_pkg::RID_ST_JUMP2;
                    end else if (flush_next) begin
                        state_reg <= rid_pkg::RID_ST_FLUSH;
                    end
                end
                rid_pkg::RID_ST_MOVE2: state_reg <= rid_pkg::RID_ST_FIRST;
                rid_pkg::RID_ST_JUMP2: state_reg <= (first_reg[15:8] == 8'hef || first_reg[15:9] == 7'h76)
                    ? rid_pkg::RID_ST_FLUSH : rid_pkg::RID_ST_FIRST;
                rid_pkg::RID_ST_FLUSH: state_reg <= rid_pkg::RID_ST_FIRST;
                default: state_reg <= rid_pkg::RID_ST_FIRST;
            endcase
        end
    end

    // ----------------------------------------
    // registered decode outputs
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_file_addr <= 12'h000; o_file_read <= 1'b0; o_file_write <= 1'b0;
            o_dest_accum <= 1'b0; o_read_pins <= 1'b0; o_bit_num <= 3'h0;
            o_literal <= 8'h00; o_move_src <= 12'h000; o_move_dst <= 12'h000;
            o_move_valid <= 1'b0; o_jump_addr <= 20'h00000; o_jump_valid <= 1'b0;
            o_jump_call <= 1'b0; o_rel_offset <= 11'h000; o_rel_valid <= 1'b0;
            o_rel_call <= 1'b0; o_cond_offset <= 8'h00; o_cond_taken <= 1'b0;
            o_tbl_mode <= rid_pkg::TBL_NONE; o_tbl_read <= 1'b0; o_tbl_write <= 1'b0;
            o_fast <= 1'b0; o_return <= 1'b0; o_int_return <= 1'b0;
            o_reenable_int <= 1'b0; o_flag_mask <= rid_pkg::FX_NONE; o_sleep <= 1'b0;
            o_wdt_clear <= 1'b0; o_push <= 1'b0; o_pop <= 1'b0;
            o_decimal_adjust <= 1'b0; o_soft_reset <= 1'b0; o_clear_prescaler <= 1'b0;
            o_exec_nop <= 1'b1; o_cycles <= 2'h1;
        end else if (take) begin
            o_file_read <= 1'b0; o_file_write <= 1'b0; o_read_pins <= 1'b0;
            o_move_valid <= 1'b0; o_jump_valid <= 1'b0; o_jump_call <= 1'b0;
            o_rel_valid <= 1'b0; o_rel_call <= 1'b0; o_cond_taken <= 1'b0;
            o_tbl_read <= 1'b0; o_tbl_write <= 1'b0; o_fast <= 1'b0;
            o_return <= 1'b0; o_int_return <= 1'b0; o_reenable_int <= 1'b0;
            o_flag_mask <= rid_pkg::FX_NONE; o_sleep <= 1'b0; o_wdt_clear <= 1'b0;
            o_push <= 1'b0; o_pop <= 1'b0; o_decimal_adjust <= 1'b0;
            o_soft_reset <= 1'b0; o_clear_prescaler <= 1'b0; o_exec_nop <= 1'b0;
            o_cycles <= cycles_next;
            if (state_reg == rid_pkg::RID_ST_MOVE2) begin
                o_move_src <= first_reg[11:0];
                o_move_dst <= w[11:0];
                o_move_valid <= 1'b1;
                o_cycles <= 2'h2;
            end else if (state_reg == rid_pkg::RID_ST_JUMP2) begin
                o_jump_addr <= {w[11:0], first_reg[7:0]};
                o_jump_valid <= 1'b1;
                o_jump_call <= (first_reg[15:9] == 7'h76);
                o_fast <= (first_reg[15:9] == 7'h76) && first_reg[rid_pkg::FAST_POS];
                o_cycles <= 2'h2;
            end else if (state_reg == rid_pkg::RID_ST_FLUSH || top == rid_pkg::SECOND_PREFIX) begin
                o_exec_nop <= 1'b1;
                o_cycles <= 2'h1;
            end else begin
                if (is_byte || is_bit) begin
                    o_file_addr <= full_addr(w[rid_pkg::ACC_POS], w[rid_pkg::FADDR_W-1:0], i_bank_select);
                    o_file_read <= 1'b1;
                    o_file_write <= writes_file;
                    o_dest_accum <= is_byte && top != 4'h6 && !w[DEST_POS_L];
                    o_read_pins <= writes_file
                        && full_addr(w[8], w[7:0], i_bank_select) == PB_ADDR;
                    o_clear_prescaler <= writes_file && i_prescaler_on_timer
                        && full_addr(w[8], w[7:0], i_bank_select) == T0_ADDR;
                end
                if (is_bit) begin
                    o_bit_num <= w[rid_pkg::BIT_LSB+2:rid_pkg::BIT_LSB];
                end
                if (is_lit) begin
                    o_literal <= w[7:0];
                    o_return <= (w[11:8] == 4'hc);
                    o_flag_mask <= (w[11:8] == 4'hf || w[11:8] == 4'h8) ? rid_pkg::FX_ARITH
                        : (w[11:8] >= 4'h9 && w[11:8] <= 4'hb) ? rid_pkg::FX_LOGIC : rid_pkg::FX_NONE;
                end
                if (is_byte) begin
                    unique case (top)
                        4'h0, 4'h2: o_flag_mask <= (top == 4'h2 && w[11:10] == 2'h3) ? rid_pkg::FX_NONE
                            : (top == 4'h0 && w[11:10] == 2'h0) ? rid_pkg::FX_NONE : rid_pkg::FX_ARITH;
                        4'h1: o_flag_mask <= rid_pkg::FX_LOGIC;
                        4'h3: o_flag_mask <= (w[11:10] == 2'h1 || w[11:10] == 2'h0) ? rid_pkg::FX_ROT
                            : rid_pkg::FX_NONE;
                        4'h4: o_flag_mask <= w[11] ? rid_pkg::FX_NONE : rid_pkg::FX_LOGIC;
                        4'h5: o_flag_mask <= (w[11:10] == 2'h0) ? rid_pkg::FX_LOGIC : rid_pkg::FX_ARITH;
                        4'h6: o_flag_mask <= (w[11:9] == 3'h5) ? rid_pkg::FX_Z
                            : (w[11:9] == 3'h6) ? rid_pkg::FX_ARITH : rid_pkg::FX_NONE;
                        default: o_flag_mask <= rid_pkg::FX_NONE;
                    endcase
                end
                if (top == 4'hd) begin
                    o_rel_offset <= w[10:0];
                    o_rel_valid <= 1'b1;
                    o_rel_call <= w[11];
                end
                if (top == 4'he && !w[11]) begin
                    o_cond_offset <= w[7:0];
                    o_cond_taken <= cond_true(w[10:8], i_status_flags);
                end
                if (w[15:3] == 13'h0001) begin
                    o_tbl_mode <= w[1:0];
                    o_tbl_read <= !w[2];
                    o_tbl_write <= w[2];
                end
                if (w[15:2] == 14'h0004) begin
                    o_return <= 1'b1;
                    o_int_return <= !w[1];
                    o_reenable_int <= !w[1];
                    o_fast <= w[0];
                end
                o_exec_nop <= (w == rid_pkg::OP_NOP);
                o_sleep <= (w == rid_pkg::OP_SLEEP);
                o_wdt_clear <= (w == rid_pkg::OP_WDT_CLEAR);
                o_push <= (w == rid_pkg::OP_PUSH);
                o_pop <= (w == rid_pkg::OP_POP);
                o_decimal_adjust <= (w == rid_pkg::OP_DECIMAL_ADJUST);
                o_soft_reset <= (w == rid_pkg::OP_SOFT_RESET);
                if (w == rid_pkg::OP_DECIMAL_ADJUST) begin
                    o_flag_mask <= rid_pkg::FX_C;
                end
            end
        end
    end

    // ----------------------------------------
    // phase code out
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_phase_code <= 2'h0;
        end else begin
            unique case (phase)
                rid_pkg::RID_PH_DECODE: o_phase_code <= 2'h1;
                rid_pkg::RID_PH_READ: o_phase_code <= 2'h2;
                rid_pkg::RID_PH_PROCESS: o_phase_code <= 2'h3;
                rid_pkg::RID_PH_WRITE: o_phase_code <= 2'h0;
                default: o_phase_code <= 2'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verification/rid_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rid_checker #(parameter int TIMER_ZERO_ADDR = 12'hfd6, parameter int PORT_B_ADDR = 12'hf81) (
    // watched decoder ports
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [1:0] o_phase_code,
    input wire logic [11:0] o_file_addr,
    input wire logic o_file_read,
    input wire logic o_file_write,
    input wire logic o_read_pins,
    input wire logic o_move_valid,
    input wire logic o_jump_valid,
    input wire logic o_rel_valid,
    input wire logic o_clear_prescaler,
    input wire logic o_exec_nop,
    input wire logic [1:0] o_cycles
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    AST_PHASE_SEQ: assert property (o_phase_code == 2'h1 |=>
        o_phase_code == 2'h2 ##1 o_phase_code == 2'h3 ##1 o_phase_code == 2'h0 ##1 o_phase_code == 2'h1)
        else $error("phase order broken");
    AST_HOLD_OUT: assert property (o_phase_code != 2'h0
        |-> $stable({o_file_addr, o_file_write, o_cycles})) else $error("outputs moved inside a cycle");
    AST_RMW_READ: assert property (o_file_write |-> o_file_read)
        else $error("file write without read");
    AST_NOP_QUIET: assert property (o_exec_nop
        |-> !(o_file_write || o_move_valid || o_jump_valid || o_rel_valid)) else $error("nop word has effects");
    AST_TWO_WORD: assert property ((o_move_valid || o_jump_valid) |-> o_cycles == 2'h2)
        else $error("two word op not two cycles");
    AST_FLUSH: assert property ((o_phase_code == 2'h0 && (o_jump_valid || o_rel_valid)) |-> ##4
        (o_exec_nop || o_jump_valid || o_rel_valid)) else $error("word after branch not flushed");
    AST_PORT_PINS: assert property (o_read_pins |-> o_file_write && o_file_addr == PORT_B_ADDR[11:0])
        else $error("pin read on wrong address");
    AST_PRESCALE: assert property (o_clear_prescaler
        |-> o_file_write && o_file_addr == TIMER_ZERO_ADDR[11:0]) else $error("prescaler clear on wrong address");
    cover property (o_move_valid);
    cover property (o_read_pins);
    cover property (o_clear_prescaler);
endmodule
bind rid_decoder rid_checker #(.TIMER_ZERO_ADDR(TIMER_ZERO_ADDR), .PORT_B_ADDR(PORT_B_ADDR)) u_rid_checker (.*);
`default_nettype wire

// >>> verification/rid_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module rid_fetch_model (
    // clock and decoder phase
    input wire logic i_sys_clk,
    input wire logic [1:0] i_phase_code,
    // fetched word
    output logic [15:0] o_instr,
    output logic o_valid
);
    logic [15:0] q [$];
    int taken = 0;
    initial o_instr = 16'h0000;
    initial o_valid = 1'b0;
    // word held until taken; idle bus toggles
    always @(posedge i_sys_clk) begin
        if (i_phase_code == 2'h3 && o_valid) taken <= taken + 1;
        if (i_phase_code == 2'h2 && q.size() > 0) begin
            o_instr <= q.pop_front();
            o_valid <= 1'b1;
        end else if (i_phase_code == 2'h2) begin
            o_instr <= ~o_instr;
            o_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_risc_instruction_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %h", $time, (a)); end end
module tb_risc_instruction_decoder;
    logic i_sys_clk = 1'b0, i_srst = 1'b1, i_skip_taken = 1'b0, i_prescaler_on_timer = 1'b0;
    logic [3:0] i_bank_select = 4'h0;
    logic [4:0] i_status_flags = 5'h00;
    logic [15:0] i_instr;
    logic i_instr_valid;
    logic [1:0] o_phase_code, o_tbl_mode, o_cycles;
    logic [11:0] o_file_addr, o_move_src, o_move_dst;
    logic [19:0] o_jump_addr;
    logic [10:0] o_rel_offset;
    logic [7:0] o_literal, o_cond_offset;
    logic [4:0] o_flag_mask;
    logic [2:0] o_bit_num;
    logic o_file_read, o_file_write, o_dest_accum, o_read_pins, o_move_valid, o_jump_valid, o_jump_call, o_rel_valid;
    logic o_rel_call, o_cond_taken, o_tbl_read, o_tbl_write, o_fast, o_return, o_int_return, o_reenable_int;
    logic o_sleep, o_wdt_clear, o_push, o_pop, o_decimal_adjust, o_soft_reset, o_clear_prescaler, o_exec_nop;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    rid_decoder u_rid_decoder (.*);
    rid_fetch_model u_rid_fetch_model (.i_sys_clk(i_sys_clk), .i_phase_code(o_phase_code), .o_instr(i_instr),
        .o_valid(i_instr_valid));
    always #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic put(input logic [15:0] w);
        int t;
        t = u_rid_fetch_model.taken;
        u_rid_fetch_model.q.push_back(w);
        for (int i = 0; i < 12 && u_rid_fetch_model.taken == t; i++) begin
            @(posedge i_sys_clk);
            #1;
        end
        if (u_rid_fetch_model.taken == t) begin
            error_cnt++;
            $display("[FAIL] %0t word not taken", $time);
        end
    endtask
    task automatic set_in(input logic [3:0] b, input logic [4:0] f, input logic s, input logic p);
        @(posedge i_sys_clk);
        i_bank_select <= b;
        i_status_flags <= f;
        i_skip_taken <= s;
        i_prescaler_on_timer <= p;
    endtask
    task automatic t_file();
        set_in(4'h3, 5'h00, 1'b0, 1'b0);
        put(16'h275a);
        `CK(o_file_addr, 12'h35a)
        `CK({o_file_read, o_file_write, o_dest_accum}, 3'b110)
        `CK(o_flag_mask, rid_pkg::FX_ARITH)
        put(16'h245a);
        `CK(o_file_addr, 12'h05a)
        `CK({o_dest_accum, o_file_write}, 2'b10)
        put(16'h0542);
        `CK({o_file_addr, o_dest_accum, o_flag_mask}, {12'h342, 1'b1, rid_pkg::FX_ARITH})
        put(16'h8f12);
        `CK({o_bit_num, o_file_addr}, {3'h7, 12'h312})
        put(16'h7f12);
        `CK({o_file_write, o_cycles}, {1'b1, 2'h1})
        put(16'h6212);
        `CK({o_file_read, o_file_write}, 2'b10)
        put(16'h4012);
        `CK(o_flag_mask, rid_pkg::FX_LOGIC)
        put(16'h34ff);
        `CK({o_flag_mask, o_file_addr}, {rid_pkg::FX_ROT, 12'h0ff})
        put(16'h0f5a);
        `CK({o_literal, o_flag_mask}, {8'h5a, rid_pkg::FX_ARITH})
    endtask
    task automatic t_two();
        put(16'hc123);
        put(16'hf456);
        `CK({o_move_valid, o_move_src, o_move_dst, o_cycles}, {1'b1, 12'h123, 12'h456, 2'h2})
        put(16'hf456);
        `CK(o_exec_nop, 1'b1)
        put(16'hed34);
        put(16'hf567);
        `CK({o_jump_valid, o_jump_call, o_fast, o_jump_addr}, {3'b111, 20'h56734})
        put(16'h0e55);
        `CK(o_exec_nop, 1'b1)
    endtask
    task automatic t_flow();
        put(16'hd7ff);
        `CK({o_rel_valid, o_rel_call, o_rel_offset, o_cycles}, {2'b10, 11'h7ff, 2'h2})
        put(16'h0e55);
        put(16'hd801);
        `CK({o_rel_call, o_rel_offset}, {1'b1, 11'h001})
        put(16'h0e55);
        put(16'h0013);
        `CK({o_return, o_fast, o_cycles}, {2'b11, 2'h2})
        put(16'h0e55);
        put(16'h0010);
        `CK({o_int_return, o_reenable_int, o_fast}, 3'b110)
        put(16'h0e55);
    endtask
    task automatic t_cond();
        logic [2:0] pos [4];
        logic f;
        pos = '{3'h2, 3'h4, 3'h1, 3'h0};
        for (int c = 0; c < 8; c++) begin
            for (int t = 0; t < 2; t++) begin
                f = t[0] ^ c[0];
                set_in(4'h0, 5'(f) << pos[c / 2], 1'b0, 1'b0);
                put({5'b11100, c[2:0], 8'h80});
                `CK({o_cond_taken, o_cond_offset}, {t[0], 8'h80})
                `CK(o_cycles, 2'(t + 1))
            end
            put(16'h0e55);
            `CK(o_exec_nop, 1'b1)
        end
    endtask
    task automatic t_ctl();
        logic [15:0] w [6];
        w = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h00ff};
        for (int i = 0; i < 6; i++) begin
            put(w[i]);
            `CK({o_sleep, o_wdt_clear, o_push, o_pop, o_decimal_adjust, o_soft_reset}, 6'h20 >> i)
        end
        for (int i = 0; i < 8; i++) begin
            put(16'h0008 + 16'(i));
            `CK({o_tbl_read, o_tbl_write, o_tbl_mode}, {i < 4, i >= 4, 2'(i)})
            `CK(o_cycles, 2'h2)
        end
    endtask
    task automatic t_misc();
        set_in(4'hf, 5'h00, 1'b0, 1'b1);
        put(16'h5381);
        `CK({o_read_pins, o_file_addr}, {1'b1, 12'hf81})
        put(16'h6bd6);
        `CK(o_clear_prescaler, 1'b1)
        put(16'h6712);
        `CK(o_cycles, 2'h1)
        set_in(4'hf, 5'h00, 1'b1, 1'b0);
        put(16'h6bd6);
        `CK(o_clear_prescaler, 1'b0)
        put(16'h6712);
        `CK(o_cycles, 2'h2)
        put(16'h0e55);
        `CK(o_exec_nop, 1'b1)
    endtask
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        t_file();
        t_two();
        t_flow();
        t_cond();
        t_ctl();
        t_misc();
        stop_test();
    end
endmodule
`default_nettype wire
